// File: design/brs_params.svh
// Constants for the bridge reset, strap capture and select block.
// Included by the package, the interface, the top module and the bench; no logic here.
`ifndef BRS_PARAMS_SVH
`define BRS_PARAMS_SVH

// Reset bit value and test-mode strap codes
`define BRS_RST_BIT 1'b0
`define BRS_TMODE_NORMAL 2'h0
`define BRS_TMODE_TRISTATE 2'h1
`define BRS_TMODE_NAND 2'h2
// Width of test-mode strap group
`define BRS_TMODE_W 2
// Image indices
`define BRS_IMAGE0 1'b0
`define BRS_IMAGE1 1'b1

`endif

// File: design/brs_pkg.sv
// Types for the bridge reset, strap capture and select block.
// Assumes brs_params.svh is on the include path.
`include "brs_params.svh"

package brs_pkg;
  typedef enum logic [1:0] {
    BRS_TEST_NORMAL,
    BRS_TEST_TRISTATE,
    BRS_TEST_NAND,
    BRS_TEST_RESERVED
  } brs_test_e;

  typedef enum logic [1:0] {
    BRS_SEL_NONE,
    BRS_SEL_REGS,
    BRS_SEL_IMG0,
    BRS_SEL_IMG1
  } brs_sel_e;

  typedef struct packed {
    logic native_protocol;
    logic eeprom_present;
    logic [`BRS_TMODE_W-1:0] test_mode;
    logic arbiter_enable;
    logic pci_disable;
  } brs_straps_s;
endpackage : brs_pkg

// File: design/brs_strap_if.sv
// Carries raw strap pins and the sampling event to the capture module.
// Both ends run on the same clock as the top.
`timescale 1ns/1ps
`include "brs_params.svh"

interface brs_strap_if;
  logic sample;
  logic burst_in_progress_strap;
  logic upper_size_strap;
  logic eeprom_data;
  logic eeprom_enable_strap;
  logic [`BRS_TMODE_W-1:0] test_mode_straps;
  logic arbiter_enable_strap;
  logic pci_disable_strap;
  brs_pkg::brs_straps_s straps;

  modport top (
    output sample, burst_in_progress_strap, upper_size_strap, eeprom_data,
    output eeprom_enable_strap, test_mode_straps, arbiter_enable_strap,
    output pci_disable_strap,
    input straps
  );
  modport cap (
    input sample, burst_in_progress_strap, upper_size_strap, eeprom_data,
    input eeprom_enable_strap, test_mode_straps, arbiter_enable_strap,
    input pci_disable_strap,
    output straps
  );
endinterface : brs_strap_if

// File: design/brs_strap_capture.sv
// Latches the mode straps when the top signals a sampling event.
// Assumes sample is a one-cycle pulse from the top's edge detect.
`timescale 1ns/1ps

module brs_strap_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strap group
  brs_strap_if.cap sif
);
  brs_pkg::brs_straps_s held;
  brs_pkg::brs_straps_s next_held;

  always_comb begin
    next_held = held;
    if (sif.sample) begin
      next_held.native_protocol =
        sif.burst_in_progress_strap & sif.upper_size_strap; // R6
      next_held.eeprom_present =
        sif.eeprom_data & sif.eeprom_enable_strap; // R7
      next_held.test_mode = sif.test_mode_straps; // R8
      next_held.arbiter_enable = sif.arbiter_enable_strap; // R11
      next_held.pci_disable = sif.pci_disable_strap; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held <= '0;
    end else begin
      held <= next_held; // R23
    end
  end

  assign sif.straps = held;

  // Straps stand still between sampling events
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !sif.sample |=> $stable(held);
  endproperty
  a_hold: assert property (p_hold) else $error("strap changed"); // R23

  property p_native;
    @(posedge clk) disable iff (!rst_n)
      sif.sample |=> held.native_protocol ==
        $past(sif.burst_in_progress_strap & sif.upper_size_strap);
  endproperty
  a_native: assert property (p_native) else $error("protocol"); // R6

  property p_eeprom;
    @(posedge clk) disable iff (!rst_n)
      sif.sample && !sif.eeprom_data |=> !held.eeprom_present;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom"); // R7
endmodule : brs_strap_capture

// File: design/brs_reset_ctrl.sv
// Summary of operation
// R1: Reset output active on PCI reset or software reset bit.
// R2: PCI reset returns every part of the block to reset state; code clears only select, burst, terminate and interrupt registers.
// R3: PCI window select routes to image 0 when select low, else 1.
// R4: Two chip selects: register access and PCI window forwarding.
// R5: Straps sampled on PCI/local reset rise, healthy fall.
// R6: Both protocol straps high selects native master and slave protocol.
// R7: EEPROM present when data line and enable strap both high.
// R8: Test-mode straps low mean normal; others select test modes.
// R9: Bus master strap high during PCI reset sets bus master bit.
// R10: Otherwise mastering waits for software to write bus master bit.
// R11: Arbiter enabled when its strap is high at reset negation.
// R12: Disable strap high retries target accesses until software clears it.
// R13: Device always terminates local cycles on either chip select.
// R14: Bursts accepted on window select; processor avoids them on registers.
// R15: Processor sets burst inhibit and external acknowledge options.
// R16: Processor avoids bus cycles while the device clock settles.
// R17: Processor sets its multifunction pin as retry input.
// R18: Processor enables synchronous external master support.
// R19: Unused strobe, size acknowledge and done inputs held high.
// R20: Processor sets image select before using the other image.
// R21: Bus bit 31 most significant; processor wiring mirrored.
// R22: Interrupt passes PCI to local as host, local to PCI as adapter.
// R23: Latched straps hold until the next reset event.
//
// Top of the reset, strap and select logic. All pins are synchronous to
// clk; clk is stable before any local cycle is started.
`timescale 1ns/1ps
`include "brs_params.svh"

module brs_reset_ctrl (
  // Clock and block reset
  input wire logic clk,
  input wire logic rst_n,
  // Reset pins, all active low
  input wire logic pci_reset_n,
  input wire logic local_reset_input_n,
  input wire logic hot_swap_healthy_input_n,
  output logic reset_output_n,
  // Software controls
  input wire logic software_reset_bit,
  input wire logic bus_master_bit_wr,
  input wire logic bus_master_bit_wdata,
  input wire logic pci_disable_clr,
  // Straps
  input wire logic burst_in_progress_strap,
  input wire logic upper_size_strap,
  input wire logic eeprom_data,
  input wire logic eeprom_enable_strap,
  input wire logic [`BRS_TMODE_W-1:0] test_mode_straps, // R21
  input wire logic bus_master_enable_strap,
  input wire logic arbiter_enable_strap,
  input wire logic pci_disable_strap,
  // Mode status
  output logic native_protocol,
  output logic eeprom_present,
  output brs_pkg::brs_test_e test_mode,
  output logic bus_master_bit,
  output logic arbiter_enable,
  output logic pci_disable,
  output logic pci_target_retry,
  // Local bus selects; chip selects active low
  input wire logic register_chip_select_n,
  input wire logic pci_window_chip_select_n,
  input wire logic image_select,
  input wire logic burst_request,
  output brs_pkg::brs_sel_e access_target,
  output logic burst_ok,
  output logic local_terminate_n,
  // PCI target request
  input wire logic pci_target_req,
  // Interrupt pass-through
  input wire logic host_mode,
  input wire logic pci_int_in_n,
  input wire logic local_interrupt_in_n,
  output logic local_interrupt_out_n,
  output logic pci_int_out_n
);
  // Global reset covers both the block pin and PCI reset
  logic grst_n;
  assign grst_n = rst_n & pci_reset_n; // R2

  // Previous pin levels for edge detection
  logic pci_q, lrst_q, hsh_q;
  logic next_pci_q, next_lrst_q, next_hsh_q;
  logic sample;

  always_comb begin
    next_pci_q = pci_reset_n;
    next_lrst_q = local_reset_input_n;
    next_hsh_q = hot_swap_healthy_input_n;
    sample = (pci_reset_n & ~pci_q) | (local_reset_input_n & ~lrst_q)
      | (~hot_swap_healthy_input_n & hsh_q); // R5
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pci_q <= 1'b1;
      lrst_q <= 1'b1;
      hsh_q <= 1'b1;
    end else begin
      pci_q <= next_pci_q;
      lrst_q <= next_lrst_q;
      hsh_q <= next_hsh_q;
    end
  end

  // Strap capture
  brs_strap_if sif ();
  assign sif.sample = sample;
  assign sif.burst_in_progress_strap = burst_in_progress_strap;
  assign sif.upper_size_strap = upper_size_strap;
  assign sif.eeprom_data = eeprom_data;
  assign sif.eeprom_enable_strap = eeprom_enable_strap;
  assign sif.test_mode_straps = test_mode_straps;
  assign sif.arbiter_enable_strap = arbiter_enable_strap;
  assign sif.pci_disable_strap = pci_disable_strap;

  // Local reset alone does not wipe straps; only block reset does
  brs_strap_capture u_cap (
    .clk(clk),
    .rst_n(rst_n),
    .sif(sif)
  );

  // Control state: reset output, bus master, disable status
  logic rst_out, bm, dis;
  logic next_rst_out, next_bm, next_dis;

  always_comb begin
    next_rst_out = ~pci_reset_n | software_reset_bit; // R1
    next_bm = bm;
    next_dis = dis;
    if (!pci_reset_n) begin
      next_bm = bus_master_enable_strap; // R9
    end else if (bus_master_bit_wr) begin
      next_bm = bus_master_bit_wdata; // R10
    end
    // Fresh strap capture wins over a software clear in the same cycle
    if (sample) begin
      next_dis = sif.pci_disable_strap; // R12
    end else if (pci_disable_clr) begin
      next_dis = 1'b0; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_out <= 1'b1;
      bm <= `BRS_RST_BIT;
      dis <= `BRS_RST_BIT;
    end else begin
      rst_out <= next_rst_out;
      bm <= next_bm;
      dis <= next_dis;
    end
  end

  // Registered outputs
  logic [1:0] sel;
  logic [1:0] next_sel;
  logic burst, next_burst, term, next_term;
  logic lint, next_lint, pint, next_pint;

  always_comb begin
    next_sel = brs_pkg::BRS_SEL_NONE;
    next_burst = 1'b0;
    next_term = 1'b0;
    if (!register_chip_select_n) begin
      next_sel = brs_pkg::BRS_SEL_REGS; // R4
      next_term = 1'b1; // R13
    end else if (!pci_window_chip_select_n) begin
      next_sel = (image_select == `BRS_IMAGE0) ? brs_pkg::BRS_SEL_IMG0
        : brs_pkg::BRS_SEL_IMG1; // R3
      next_burst = burst_request; // R14
      next_term = 1'b1; // R13
    end
    next_lint = host_mode & ~pci_int_in_n; // R22
    next_pint = ~host_mode & ~local_interrupt_in_n; // R22
  end

  always_ff @(posedge clk) begin
    if (!grst_n) begin
      sel <= brs_pkg::BRS_SEL_NONE;
      burst <= 1'b0;
      term <= 1'b0;
      lint <= 1'b0;
      pint <= 1'b0;
    end else begin
      sel <= next_sel;
      burst <= next_burst;
      term <= next_term;
      lint <= next_lint;
      pint <= next_pint;
    end
  end

  assign reset_output_n = ~rst_out;
  assign native_protocol = sif.straps.native_protocol;
  assign eeprom_present = sif.straps.eeprom_present;
  assign test_mode = brs_pkg::brs_test_e'(sif.straps.test_mode); // R8
  assign arbiter_enable = sif.straps.arbiter_enable; // R11
  assign bus_master_bit = bm;
  assign pci_disable = dis;
  assign pci_target_retry = pci_target_req & dis; // R12
  assign access_target = brs_pkg::brs_sel_e'(sel);
  assign burst_ok = burst;
  assign local_terminate_n = ~term;
  assign local_interrupt_out_n = ~lint;
  assign pci_int_out_n = ~pint;

  // Checks
  property p_rst_out;
    @(posedge clk) disable iff (!rst_n)
      (!pci_reset_n || software_reset_bit) |=> !reset_output_n;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset out"); // R1

  property p_rst_rel;
    @(posedge clk) disable iff (!rst_n)
      (pci_reset_n && !software_reset_bit) |=> reset_output_n;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("reset stuck"); // R1

  property p_global;
    @(posedge clk) disable iff (!rst_n)
      !pci_reset_n |=> access_target == brs_pkg::BRS_SEL_NONE
        && local_terminate_n;
  endproperty
  a_global: assert property (p_global) else $error("global"); // R2

  property p_image;
    @(posedge clk) disable iff (!grst_n)
      register_chip_select_n && !pci_window_chip_select_n && image_select
      |=> access_target == brs_pkg::BRS_SEL_IMG1;
  endproperty
  a_image: assert property (p_image) else $error("image"); // R3

  property p_regs;
    @(posedge clk) disable iff (!grst_n)
      !register_chip_select_n |=> access_target == brs_pkg::BRS_SEL_REGS
        && !burst_ok;
  endproperty
  a_regs: assert property (p_regs) else $error("regs"); // R4

  property p_burst;
    @(posedge clk) disable iff (!grst_n)
      register_chip_select_n && !pci_window_chip_select_n
      |=> burst_ok == $past(burst_request);
  endproperty
  a_burst: assert property (p_burst) else $error("burst"); // R14

  property p_sample;
    @(posedge clk) disable iff (!rst_n)
      $rose(pci_reset_n) && pci_disable_strap |=> pci_disable;
  endproperty
  a_sample: assert property (p_sample) else $error("sample"); // R5

  // Edge history is only valid once block reset has been gone a cycle
  property p_arb;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && $fell(hot_swap_healthy_input_n)
      |=> arbiter_enable == $past(arbiter_enable_strap);
  endproperty
  a_arb: assert property (p_arb) else $error("arbiter"); // R11

  property p_tmode;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && $rose(local_reset_input_n)
      |=> test_mode == $past(test_mode_straps);
  endproperty
  a_tmode: assert property (p_tmode) else $error("test mode"); // R8

  property p_bm;
    @(posedge clk) disable iff (!rst_n)
      !pci_reset_n |=> bus_master_bit == $past(bus_master_enable_strap);
  endproperty
  a_bm: assert property (p_bm) else $error("bus master"); // R9

  property p_bm_hold;
    @(posedge clk) disable iff (!rst_n)
      pci_reset_n && !bus_master_bit_wr |=> $stable(bus_master_bit);
  endproperty
  a_bm_hold: assert property (p_bm_hold) else $error("bm moved"); // R10

  property p_retry;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && $rose(pci_reset_n) && pci_disable_strap
      |=> pci_disable && pci_target_retry == pci_target_req;
  endproperty
  a_retry: assert property (p_retry) else $error("retry"); // R12

  property p_term;
    @(posedge clk) disable iff (!grst_n)
      !(register_chip_select_n && pci_window_chip_select_n)
      |=> !local_terminate_n;
  endproperty
  a_term: assert property (p_term) else $error("terminate"); // R13

  property p_int;
    @(posedge clk) disable iff (!grst_n)
      host_mode && !pci_int_in_n |=> !local_interrupt_out_n && pci_int_out_n;
  endproperty
  a_int: assert property (p_int) else $error("interrupt"); // R22

  property p_adapter;
    @(posedge clk) disable iff (!grst_n)
      !host_mode && !local_interrupt_in_n
      |=> !pci_int_out_n && local_interrupt_out_n;
  endproperty
  a_adapter: assert property (p_adapter) else $error("adapter"); // R22
endmodule : brs_reset_ctrl

// File: verification/brs_proc_model.sv
// Processor-side model: drives the two chip selects, image select, burst.
// Assumes access() is called by the bench once clk and reset are settled.
`timescale 1ns/1ps

module brs_proc_model (
  // Clock
  input wire logic clk,
  // Selects towards the device
  output logic register_chip_select_n,
  output logic pci_window_chip_select_n,
  output logic image_select,
  output logic burst_request,
  // Device answer
  input wire logic local_terminate_n,
  input wire brs_pkg::brs_sel_e access_target,
  input wire logic burst_ok
);
  // Processor setup the device relies on
  localparam logic [1:0] RETRY_PIN_FIELD = 2'h2;
  localparam logic SYNC_EXT_MASTER = 1'b1;
  localparam logic EXT_ACK_OPTION = 1'b1;
  // Unused strobe, size acknowledge and done lines idle high
  localparam logic UNUSED_INPUT_LEVEL = 1'b1;

  initial begin
    register_chip_select_n = 1'b1;
    pci_window_chip_select_n = 1'b1;
    image_select = 1'b0;
    burst_request = 1'b0;
  end

  // No own acknowledge: the cycle ends on the device's termination or after 8 cycles
  task automatic access(input logic win, input logic img, input logic bst,
                        output logic ok, output logic [1:0] tgt,
                        output logic bok);
    int n;
    ok = 1'b0;
    tgt = 2'h0;
    bok = 1'b0;
    @(negedge clk);
    image_select = img;
    @(negedge clk);
    register_chip_select_n = win;
    pci_window_chip_select_n = !win;
    burst_request = bst & win;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge clk);
      ok = (local_terminate_n === 1'b0);
      tgt = access_target;
      bok = burst_ok;
    end
    // Hold selects through the edge that samples the termination
    @(negedge clk);
    register_chip_select_n = 1'b1;
    pci_window_chip_select_n = 1'b1;
    // Released burst line is driven to the inverse of its last value
    burst_request = !burst_request;
  endtask : access
endmodule : brs_proc_model

// File: verification/tb_top.sv
// Self-checking bench for the reset, strap capture and select block.
// Assumes brs_pkg and the design files are compiled first.
`timescale 1ns/1ps
`include "brs_params.svh"

module tb_top;
  logic clk, rst_n, pci_reset_n, local_reset_input_n;
  logic hot_swap_healthy_input_n, reset_output_n, software_reset_bit;
  logic bus_master_bit_wr, bus_master_bit_wdata, pci_disable_clr;
  logic burst_in_progress_strap, upper_size_strap, eeprom_data;
  logic eeprom_enable_strap, bus_master_enable_strap, arbiter_enable_strap;
  logic [`BRS_TMODE_W-1:0] test_mode_straps;
  logic pci_disable_strap, native_protocol, eeprom_present, bus_master_bit;
  logic arbiter_enable, pci_disable, pci_target_retry, register_chip_select_n;
  logic pci_window_chip_select_n, image_select, burst_request, burst_ok;
  logic local_terminate_n, pci_target_req, host_mode, pci_int_in_n;
  logic local_interrupt_in_n, local_interrupt_out_n, pci_int_out_n;
  brs_pkg::brs_test_e test_mode;
  brs_pkg::brs_sel_e access_target;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  brs_reset_ctrl DUT (.clk, .rst_n, .pci_reset_n, .local_reset_input_n,
    .hot_swap_healthy_input_n, .reset_output_n, .software_reset_bit,
    .bus_master_bit_wr, .bus_master_bit_wdata, .pci_disable_clr,
    .burst_in_progress_strap, .upper_size_strap, .eeprom_data,
    .eeprom_enable_strap, .test_mode_straps, .bus_master_enable_strap,
    .arbiter_enable_strap, .pci_disable_strap, .native_protocol,
    .eeprom_present, .test_mode, .bus_master_bit, .arbiter_enable,
    .pci_disable, .pci_target_retry, .register_chip_select_n,
    .pci_window_chip_select_n, .image_select, .burst_request, .access_target,
    .burst_ok, .local_terminate_n, .pci_target_req, .host_mode,
    .pci_int_in_n, .local_interrupt_in_n, .local_interrupt_out_n,
    .pci_int_out_n);

  brs_proc_model u_proc (.clk, .register_chip_select_n,
    .pci_window_chip_select_n, .image_select, .burst_request,
    .local_terminate_n, .access_target, .burst_ok);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Strap byte: burst, size, eeprom data, eeprom enable, test[1:0], arb, dis
  function automatic logic [7:0] exp_straps(input logic [7:0] s);
    return {2'h0, s[7] & s[6], s[5] & s[4], s[3:2], s[1], s[0]};
  endfunction : exp_straps

  function automatic logic [7:0] got_straps();
    return {2'h0, native_protocol, eeprom_present, test_mode,
            arbiter_enable, pci_disable};
  endfunction : got_straps

  task automatic set_straps(input logic [7:0] s);
    {burst_in_progress_strap, upper_size_strap, eeprom_data,
     eeprom_enable_strap, test_mode_straps, arbiter_enable_strap,
     pci_disable_strap} = s;
  endtask : set_straps

  // Kind 0 PCI reset pulse, 1 local reset pulse, else healthy pulse
  task automatic fire(input int k);
    @(negedge clk);
    case (k)
      0: pci_reset_n = 1'b0;
      1: local_reset_input_n = 1'b0;
      default: hot_swap_healthy_input_n = 1'b0;
    endcase
    repeat (2) @(negedge clk);
    if (k == 0) begin
      chk(reset_output_n, 1'b0);
      chk(bus_master_bit, bus_master_enable_strap);
      chk(access_target, brs_pkg::BRS_SEL_NONE);
    end
    pci_reset_n = 1'b1;
    local_reset_input_n = 1'b1;
    hot_swap_healthy_input_n = 1'b1;
  endtask : fire

  initial begin
    logic [7:0] s;
    logic ok, w, im, b, bo;
    logic [1:0] t;
    logic [1:0] iexp;
    {rst_n, pci_reset_n, software_reset_bit, bus_master_bit_wr} = 4'h0;
    {bus_master_bit_wdata, pci_disable_clr, pci_target_req} = 3'h0;
    {local_reset_input_n, hot_swap_healthy_input_n} = 2'h3;
    {host_mode, pci_int_in_n, local_interrupt_in_n} = 3'h3;
    bus_master_enable_strap = 1'b0;
    set_straps(8'h00);
    void'($urandom(72721));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(reset_output_n, 1'b0);
    pci_reset_n = 1'b1;
    // Corners all-low and all-high first, then random straps and events
    for (int i = 0; i < 24; i++) begin
      s = (i < 2) ? {8{i[0]}} : 8'($urandom);
      set_straps(s);
      bus_master_enable_strap = 1'($urandom);
      fire(i < 3 ? i : $urandom_range(0, 2));
      repeat (3) @(negedge clk);
      chk(got_straps(), exp_straps(s));
      chk(reset_output_n, 1'b1);
      set_straps(~s);
      repeat (3) @(negedge clk);
      chk(got_straps(), exp_straps(s));
    end
    bus_master_enable_strap = 1'b0;
    fire(0);
    for (int v = 1; v >= 0; v--) begin
      bus_master_bit_wr = 1'b1;
      bus_master_bit_wdata = v[0];
      @(negedge clk);
      bus_master_bit_wr = 1'b0;
      @(negedge clk);
      chk(bus_master_bit, v[0]);
    end
    software_reset_bit = 1'b1;
    repeat (2) @(negedge clk);
    chk(reset_output_n, 1'b0);
    software_reset_bit = 1'b0;
    repeat (2) @(negedge clk);
    chk(reset_output_n, 1'b1);
    set_straps(8'h01);
    fire(1);
    repeat (3) @(negedge clk);
    pci_target_req = 1'b1;
    @(negedge clk);
    chk(pci_target_retry, 1'b1);
    pci_disable_clr = 1'b1;
    @(negedge clk);
    pci_disable_clr = 1'b0;
    @(negedge clk);
    chk({pci_disable, pci_target_retry}, 2'h0);
    // Model waits for a settled clock before any cycle
    for (int i = 0; i < 10; i++) begin
      w = (i < 4) ? (i != 0) : 1'($urandom);
      im = (i < 4) ? i[0] : 1'($urandom);
      b = (i < 4) ? i[1] : 1'($urandom);
      u_proc.access(w, im, b, ok, t, bo);
      chk(ok, 1'b1);
      chk(t, !w ? 2'h1 : {1'b1, im});
      chk(bo, w & b);
      repeat (2) @(negedge clk);
      chk(access_target, brs_pkg::BRS_SEL_NONE);
    end
    for (int i = 0; i < 4; i++) begin
      host_mode = i[1];
      pci_int_in_n = i[0];
      local_interrupt_in_n = !i[0];
      repeat (2) @(negedge clk);
      if (i[1]) chk(local_interrupt_out_n, i[0]);
      else chk(pci_int_out_n, !i[0]);
      iexp = {~i[1] | i[0], i[1] | ~i[0]};
      chk({local_interrupt_out_n, pci_int_out_n}, iexp);
    end
    test_done();
  end
endmodule : tb_top
